/* File: design/asc_pkg.sv */
// Package for the alarm sending controller
package asc_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_TONE   = 8'h04;
   localparam logic [7:0] OFS_TIMER  = 8'h08;
   localparam logic [7:0] OFS_CLASS0 = 8'h0C;
   localparam logic [7:0] OFS_CLASS1 = 8'h10;
   localparam logic [7:0] OFS_CLASS2 = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_SCANLO = 8'h1C;
   localparam logic [7:0] OFS_SCANHI = 8'h20;

   // Control register field positions
   localparam int CTRL_SEND_EN   = 0;
   localparam int CTRL_EQUAL_OPT = 1;
   localparam int CTRL_COTS_OPT  = 2;
   localparam int CTRL_KEEP_OPT  = 3;
   localparam int CTRL_TELEM     = 4;
   localparam int CTRL_EXCL_LSB  = 5;
   localparam int CTRL_DEDICATED = 8;
   localparam int CTRL_WIDTH     = 9;

   // Timer register field positions and limits
   localparam int          TMR_ANS_LSB  = 0;
   localparam int          TMR_CHK_LSB  = 8;
   localparam int          TMR_DLY_LSB  = 16;
   localparam logic [7:0]  MAX_ANS_S    = 8'd155;
   localparam logic [7:0]  MAX_CHK_S    = 8'd155;
   localparam logic [11:0] MAX_DLY_S    = 12'd3600;
   localparam logic [31:0] TIMER_RESET  = 32'h0000_3C3C;
   localparam logic [31:0] TONE_RESET   = 32'h0009_8101;

   // Scan point layout, numbered from one
   localparam int NUM_SCAN     = 64;
   localparam int FIRST_CUST   = 22;
   localparam int LAST_CUST    = 63;
   localparam int FIRST_TELEM  = 60;
   localparam int ACK_POINT    = 64;

   // One second timebase
   localparam longint TICK_PERIOD_NS = 1_000_000_000;
   localparam longint CLK_PERIOD_NS  = 5;
   localparam int     TICK_CYCLES_DFLT = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

   // Alarm classes in rank order
   typedef enum logic [1:0] {
      CLS_NONE  = 2'b00,
      CLS_MINOR = 2'b01,
      CLS_MAJOR = 2'b10,
      CLS_CAT   = 2'b11
   } asc_class_e;

   // Tone codes for sending and checking
   typedef enum logic [3:0] {
      TONE_SILENCE = 4'h0,
      TONE_BUSY    = 4'h1,
      TONE_SVC_HI  = 4'h2,
      TONE_SVC_LO  = 4'h3,
      TONE_CONT_RB = 4'h4,
      TONE_HIGH    = 4'h5,
      TONE_LOW     = 4'h6,
      TONE_OVERFLOW_TONE    = 4'h7,
      TONE_CODE1   = 4'h8,
      TONE_CODE2   = 4'h9
   } asc_tone_e;

   // Sending sequence states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_DELAY   = 3'b001,
      ST_RING    = 3'b010,
      ST_WAITCHK = 3'b011,
      ST_HOLD    = 3'b100,
      ST_RELEASE = 3'b101
   } asc_state_e;

   // Checking call request from call processing
   typedef struct packed {
      logic req;
      logic from_alarm_trunk;
      logic classmark;
   } asc_check_req_s;

endpackage : asc_pkg

/* File: design/asc_alarm_sender.sv */
// Alarm sending and checking controller with APB register access
//
// How it works
// R1: Software enable switches alarm sending on/off.
// R2: With no alarm, any alarm engages sending.
// R3: Existing alarm: only higher (or equal) class.
// R4: Seize dedicated or one-way trunk, apply tone.
// R5: Sending tone picked from seven choices.
// R6: Tone holds until clear or checking dial.
// R7: No answer in time: release, seize another.
// R8: No check dial after answer: seize another.
// R9: Each class can be excluded from sending.
// R10: Optional delay up to sixty minutes first.
// R11: Checking call hears highest active class tone.
// R12: Four assignable checking tones with defaults.
// R13: Checking call releases sending unless kept.
// R14: Only alarm operator or classmark; else intercept.
// R15: Sixty-four scan inputs, numbered from one.
// R16: Points 1-21, 64 fixed; 22-63 assignable.
// R17: Telemetry fixes 60-63, leaving thirty-eight.
// R18: Closed contact means alarm, open none.
// R19: Point 64 is the acknowledge indication.
// R20: Classes ranked none, minor, major, catastrophic.
// R21: Intervals timed from a one-second tick.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module asc_alarm_sender #(
   parameter int TICK_CYCLES = asc_pkg::TICK_CYCLES_DFLT,
   parameter int TRUNK_COUNT = 4,
   parameter int TRUNK_W     = 2
) (
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [7:0]             PADDR,
   input  wire logic [31:0]            PWDATA,
   output var  logic [31:0]            PRDATA,
   output var  logic                   PREADY,
   output var  logic                   PSLVERR,
   input  wire logic [63:0]            ALARM_SCAN,
   input  wire logic                   TRUNK_ANSWER,
   input  wire asc_pkg::asc_check_req_s CHECK_IN,
   output var  logic                   TRUNK_SEIZE,
   output var  logic                   TRUNK_DEDICATED,
   output var  logic [TRUNK_W-1:0]     TRUNK_SELECT,
   output var  logic                   TONE_ON,
   output var  logic [3:0]             TONE_CODE,
   output var  logic                   CHECK_CONNECT,
   output var  logic                   CHECK_INTERCEPT,
   output var  logic [3:0]             CHECK_TONE,
   output var  logic                   ACK_IND
);

   // Parameters the logic cannot serve are refused
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
   end
   if (TRUNK_COUNT < 2 || TRUNK_COUNT > (1 << TRUNK_W)) begin : g_bad_trunk
      $error("TRUNK_COUNT must be 2 to 2**TRUNK_W");
   end

   // Class of a fixed point, by its number
   function automatic logic [1:0] fixed_class(input int num);
      case (num)
         1, 5, 6, 10, 11:    fixed_class = asc_pkg::CLS_MAJOR;
         4:                  fixed_class = asc_pkg::CLS_CAT;
         2, 9, 12, 13, 16,
         17, 18, 19, 20, 21: fixed_class = asc_pkg::CLS_MINOR;
         default:            fixed_class = asc_pkg::CLS_NONE;
      endcase
   endfunction : fixed_class

   // Class excluded from sending
   function automatic logic excluded(input logic [1:0] cls, input logic [2:0] excl);
      excluded = (cls == asc_pkg::CLS_NONE) || excl[cls - 2'd1];
   endfunction : excluded

   // Registers
   logic [asc_pkg::CTRL_WIDTH-1:0] ctrl_reg;
   logic [31:0]                    tone_reg;
   logic [31:0]                    timer_reg;
   logic [31:0]                    class_reg [3];
   logic [63:0]                    scan_meta_reg;
   logic [63:0]                    scan_reg;
   logic [63:0]                    scan_prev_reg;
   logic [31:0]                    tick_cnt_reg;
   logic                           tick_reg;
   logic [11:0]                    sec_cnt_reg;
   logic [1:0]                     sent_class_reg;
   logic [TRUNK_W-1:0]             trunk_reg;
   asc_pkg::asc_state_e            state_reg;
   asc_pkg::asc_state_e            state_next;

   // Decoded control fields
   logic                           send_en;
   logic                           equal_opt;
   logic                           cots_opt;
   logic                           keep_opt;
   logic                           telem;
   logic [2:0]                     excl;
   logic [7:0]                     ans_s;
   logic [7:0]                     chk_s;
   logic [11:0]                    dly_s;

   assign send_en   = ctrl_reg[asc_pkg::CTRL_SEND_EN];
   assign equal_opt = ctrl_reg[asc_pkg::CTRL_EQUAL_OPT];
   assign cots_opt  = ctrl_reg[asc_pkg::CTRL_COTS_OPT];
   assign keep_opt  = ctrl_reg[asc_pkg::CTRL_KEEP_OPT];
   assign telem     = ctrl_reg[asc_pkg::CTRL_TELEM];
   assign excl      = ctrl_reg[asc_pkg::CTRL_EXCL_LSB +: 3];
   assign ans_s     = timer_reg[asc_pkg::TMR_ANS_LSB +: 8];
   assign chk_s     = timer_reg[asc_pkg::TMR_CHK_LSB +: 8];
   assign dly_s     = timer_reg[asc_pkg::TMR_DLY_LSB +: 12];

   // Scan inputs are contact pins, so two flops before use
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         scan_meta_reg <= 64'h0;
         scan_reg      <= 64'h0;
         scan_prev_reg <= 64'h0;
      end else begin
         scan_meta_reg <= ALARM_SCAN;
         scan_reg      <= scan_meta_reg;  // [R15] [R18]
         scan_prev_reg <= scan_reg;
      end
   end

   // Per-point class, highest active class and best new alarm
   logic [1:0] pt_class [64];
   logic [1:0] highest;
   logic [1:0] highest_q;
   logic [1:0] new_class;

   always_comb begin
      highest   = asc_pkg::CLS_NONE;
      highest_q = asc_pkg::CLS_NONE;
      new_class = asc_pkg::CLS_NONE;
      for (int i = 0; i < asc_pkg::NUM_SCAN; i++) begin
         // Bit i is point i+1; assignable points read their class field
         if (i + 1 >= asc_pkg::FIRST_CUST && i + 1 <= asc_pkg::LAST_CUST &&
             !(telem && i + 1 >= asc_pkg::FIRST_TELEM)) begin
            pt_class[i] = class_reg[(i + 1 - asc_pkg::FIRST_CUST) / 16]
                          [2 * ((i + 1 - asc_pkg::FIRST_CUST) % 16) +: 2];  // [R16] [R17]
         end else begin
            pt_class[i] = fixed_class(i + 1);  // [R16] [R19]
         end
         if (scan_reg[i] && pt_class[i] > highest) begin
            highest = pt_class[i];  // [R20]
         end
         if (scan_reg[i] && !excluded(pt_class[i], excl) && pt_class[i] > highest_q) begin
            highest_q = pt_class[i];  // [R9]
         end
         if (scan_reg[i] && !scan_prev_reg[i] && !excluded(pt_class[i], excl) &&
             pt_class[i] > new_class) begin
            new_class = pt_class[i];
         end
      end
   end

   // Engage on a higher new alarm, or equal by option
   logic trigger;
   assign trigger = send_en && (new_class != asc_pkg::CLS_NONE) &&
                    ((sent_class_reg == asc_pkg::CLS_NONE) ||                 // [R2]
                     (new_class > sent_class_reg) ||                          // [R3] [R20]
                     (equal_opt && new_class == sent_class_reg));             // [R3]

   // One-second tick from the system clock
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_cnt_reg <= 32'h0;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= 32'h0;
         tick_reg     <= 1'b1;  // [R21]
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
         tick_reg     <= 1'b0;
      end
   end

   // Checking calls: signalled operator or classmark line
   logic check_ok;
   logic check_from_op;
   assign check_from_op = CHECK_IN.from_alarm_trunk &&
                          (state_reg == asc_pkg::ST_WAITCHK || state_reg == asc_pkg::ST_HOLD);
   assign check_ok = CHECK_IN.req && (CHECK_IN.classmark || check_from_op);  // [R14]

   logic seconds_up;
   assign seconds_up = tick_reg && (sec_cnt_reg <= 12'h1);

   // Sending sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         asc_pkg::ST_IDLE: begin
            if (trigger) begin
               state_next = (dly_s == 12'h0) ? asc_pkg::ST_RING : asc_pkg::ST_DELAY;  // [R10]
            end
         end
         asc_pkg::ST_DELAY: begin
            if (seconds_up) begin
               state_next = asc_pkg::ST_RING;  // [R10]
            end
         end
         asc_pkg::ST_RING: begin
            if (TRUNK_ANSWER) begin
               state_next = asc_pkg::ST_WAITCHK;
            end else if (seconds_up) begin
               state_next = asc_pkg::ST_RELEASE;  // [R7]
            end
         end
         asc_pkg::ST_WAITCHK: begin
            if (check_ok && check_from_op) begin
               state_next = keep_opt ? asc_pkg::ST_HOLD : asc_pkg::ST_IDLE;  // [R13]
            end else if (seconds_up) begin
               state_next = asc_pkg::ST_RELEASE;  // [R8]
            end
         end
         asc_pkg::ST_HOLD:    state_next = asc_pkg::ST_HOLD;
         asc_pkg::ST_RELEASE: state_next = asc_pkg::ST_RING;
         default:             state_next = asc_pkg::ST_IDLE;
      endcase
      // Cancel or a cleared alarm ends sending from anywhere
      if (!send_en || highest_q == asc_pkg::CLS_NONE) begin
         state_next = asc_pkg::ST_IDLE;  // [R1] [R6]
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= asc_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Seconds counter reloads on each timed state entry
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sec_cnt_reg <= 12'h0;
      end else if (state_next != state_reg) begin
         case (state_next)
            asc_pkg::ST_DELAY:   sec_cnt_reg <= dly_s;
            asc_pkg::ST_RING:    sec_cnt_reg <= {4'h0, ans_s};
            asc_pkg::ST_WAITCHK: sec_cnt_reg <= {4'h0, chk_s};
            default:             sec_cnt_reg <= 12'h0;
         endcase
      end else if (tick_reg && sec_cnt_reg != 12'h0) begin
         sec_cnt_reg <= sec_cnt_reg - 12'h1;  // [R21]
      end
   end

   // Reported class: raised by each higher new alarm, cleared with the alarm
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sent_class_reg <= asc_pkg::CLS_NONE;
      end else if (!send_en || highest_q == asc_pkg::CLS_NONE) begin
         sent_class_reg <= asc_pkg::CLS_NONE;
      end else if (trigger && new_class > sent_class_reg) begin
         sent_class_reg <= new_class;  // [R3]
      end
   end

   // Next trunk after each release
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         trunk_reg <= '0;
      end else if (state_reg == asc_pkg::ST_RELEASE) begin
         trunk_reg <= (trunk_reg == TRUNK_W'(TRUNK_COUNT - 1)) ? '0
                      : trunk_reg + TRUNK_W'(1);  // [R7] [R8]
      end
   end

   // Trunk and tone outputs; seizure carries no digits, only tone
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         TRUNK_SEIZE     <= 1'b0;
         TRUNK_DEDICATED <= 1'b0;
         TRUNK_SELECT    <= '0;
         TONE_ON         <= 1'b0;
         TONE_CODE       <= asc_pkg::TONE_SILENCE;
      end else begin
         TRUNK_SEIZE     <= state_next == asc_pkg::ST_RING ||
                            state_next == asc_pkg::ST_WAITCHK ||
                            state_next == asc_pkg::ST_HOLD;  // [R4]
         TRUNK_DEDICATED <= ctrl_reg[asc_pkg::CTRL_DEDICATED];  // [R4]
         TRUNK_SELECT    <= (state_reg == asc_pkg::ST_RELEASE) ?
                            ((trunk_reg == TRUNK_W'(TRUNK_COUNT - 1)) ? '0
                             : trunk_reg + TRUNK_W'(1)) : trunk_reg;
         TONE_ON         <= state_next == asc_pkg::ST_RING ||
                            state_next == asc_pkg::ST_WAITCHK ||
                            (state_next == asc_pkg::ST_HOLD && !cots_opt);  // [R6]
         TONE_CODE       <= tone_reg[3:0];  // [R5]
      end
   end

   // Checking call answer: connect with class tone or intercept
   logic [3:0] class_tone;
   always_comb begin
      case (highest)
         asc_pkg::CLS_CAT:   class_tone = tone_reg[7:4];
         asc_pkg::CLS_MAJOR: class_tone = tone_reg[11:8];
         asc_pkg::CLS_MINOR: class_tone = tone_reg[15:12];
         default:            class_tone = tone_reg[19:16];
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         CHECK_CONNECT   <= 1'b0;
         CHECK_INTERCEPT <= 1'b0;
         CHECK_TONE      <= asc_pkg::TONE_SILENCE;
         ACK_IND         <= 1'b0;
      end else begin
         CHECK_CONNECT   <= check_ok;                       // [R14]
         CHECK_INTERCEPT <= CHECK_IN.req && !check_ok;      // [R14]
         if (check_ok) begin
            CHECK_TONE <= class_tone;  // [R11] [R12]
         end
         ACK_IND <= scan_reg[asc_pkg::ACK_POINT - 1];  // [R19]
      end
   end

   // APB: one wait state, registered answer
   logic       apb_access;
   logic       addr_ok;
   logic [31:0] rd_data;
   assign apb_access = PSEL && PENABLE && !PREADY;

   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0;
      case (PADDR)
         asc_pkg::OFS_CTRL:   rd_data = {{(32 - asc_pkg::CTRL_WIDTH){1'b0}}, ctrl_reg};
         asc_pkg::OFS_TONE:   rd_data = tone_reg;
         asc_pkg::OFS_TIMER:  rd_data = timer_reg;
         asc_pkg::OFS_CLASS0: rd_data = class_reg[0];
         asc_pkg::OFS_CLASS1: rd_data = class_reg[1];
         asc_pkg::OFS_CLASS2: rd_data = class_reg[2];
         asc_pkg::OFS_STATUS: rd_data = {16'h0, 8'(trunk_reg), ACK_IND, state_reg,
                                         sent_class_reg, highest};
         asc_pkg::OFS_SCANLO: rd_data = scan_reg[31:0];
         asc_pkg::OFS_SCANHI: rd_data = scan_reg[63:32];
         default:             addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
      end else begin
         PREADY  <= apb_access;
         PSLVERR <= apb_access && !addr_ok;
         PRDATA  <= (apb_access && !PWRITE && addr_ok) ? rd_data : 32'h0;
      end
   end

   // Writes land at the edge where the master sees ready; intervals saturate
   logic wr;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_reg  <= '0;
         tone_reg  <= asc_pkg::TONE_RESET;
         timer_reg <= asc_pkg::TIMER_RESET;
         class_reg <= '{default: 32'h0};
      end else if (wr) begin
         case (PADDR)
            asc_pkg::OFS_CTRL:   ctrl_reg <= PWDATA[asc_pkg::CTRL_WIDTH-1:0];  // [R1] [R9]
            asc_pkg::OFS_TONE: begin
               // Sending tone limited to the seven choices, busy by fallback
               tone_reg[31:4] <= {12'h0, PWDATA[19:4]};  // [R12]
               tone_reg[3:0]  <= (PWDATA[3:0] >= asc_pkg::TONE_BUSY &&
                                  PWDATA[3:0] <= asc_pkg::TONE_OVERFLOW_TONE) ?
                                 PWDATA[3:0] : asc_pkg::TONE_BUSY;  // [R5]
            end
            asc_pkg::OFS_TIMER: begin
               timer_reg[7:0]   <= (PWDATA[7:0] > asc_pkg::MAX_ANS_S) ?
                                   asc_pkg::MAX_ANS_S : PWDATA[7:0];  // [R7]
               timer_reg[15:8]  <= (PWDATA[15:8] > asc_pkg::MAX_CHK_S) ?
                                   asc_pkg::MAX_CHK_S : PWDATA[15:8];  // [R8]
               timer_reg[27:16] <= (PWDATA[27:16] > asc_pkg::MAX_DLY_S) ?
                                   asc_pkg::MAX_DLY_S : PWDATA[27:16];  // [R10]
               timer_reg[31:28] <= 4'h0;
            end
            asc_pkg::OFS_CLASS0: class_reg[0] <= PWDATA;  // [R16]
            asc_pkg::OFS_CLASS1: class_reg[1] <= PWDATA;
            asc_pkg::OFS_CLASS2: class_reg[2] <= {12'h0, PWDATA[19:0]};
            default: ;
         endcase
      end
   end

endmodule : asc_alarm_sender

`default_nettype wire

/* File: bench/asc_alarm_sender_assertions.sv */
// Port-level assertions for the alarm sending controller
`timescale 1ns/100ps
`default_nettype none
module asc_alarm_sender_checker #(
   parameter int TRUNK_W = 2
) (
   input wire logic                    CLK,
   input wire logic                    RST_N,
   input wire logic                    PSEL,
   input wire logic                    PENABLE,
   input wire logic                    PWRITE,
   input wire logic [7:0]              PADDR,
   input wire logic [31:0]             PWDATA,
   input wire logic                    PREADY,
   input wire logic                    PSLVERR,
   input wire logic [63:0]             ALARM_SCAN,
   input wire asc_pkg::asc_check_req_s CHECK_IN,
   input wire logic                    TRUNK_SEIZE,
   input wire logic [TRUNK_W-1:0]      TRUNK_SELECT,
   input wire logic                    TONE_ON,
   input wire logic [3:0]              TONE_CODE,
   input wire logic                    CHECK_CONNECT,
   input wire logic                    CHECK_INTERCEPT,
   input wire logic                    ACK_IND
);
   logic [2:0] en_hist;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Enable history; a trigger in flight may land after a disable
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) en_hist <= 3'h0;
      else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == asc_pkg::OFS_CTRL)
         en_hist <= {en_hist[1:0], PWDATA[asc_pkg::CTRL_SEND_EN]};
      else en_hist <= {en_hist[1:0], en_hist[0]};
   end
   property p_ready_next; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
   a_ready_next: assert property (p_ready_next) else $error("no answer after access");
   property p_ready_one; PREADY |=> !PREADY; endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready held too long");
   property p_err_ready; PSLVERR |-> PREADY; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_send_off; en_hist == 3'h0 |-> !$rose(TRUNK_SEIZE); endproperty
   a_send_off: assert property (p_send_off) else $error("seized while off");
   property p_seize_tone; $rose(TRUNK_SEIZE) |-> TONE_ON; endproperty
   a_seize_tone: assert property (p_seize_tone) else $error("seize without tone");
   property p_tone_code; TONE_ON |-> TONE_CODE inside {[4'h1:4'h7]}; endproperty
   a_tone_code: assert property (p_tone_code) else $error("bad sending tone");
   property p_retry;
      $fell(TRUNK_SEIZE) ##1 TRUNK_SEIZE |-> TRUNK_SELECT != $past(TRUNK_SELECT, 2);
   endproperty
   a_retry: assert property (p_retry) else $error("retry on same trunk");
   property p_chk_ok; CHECK_IN.req && CHECK_IN.classmark |=> CHECK_CONNECT && !CHECK_INTERCEPT;
   endproperty
   a_chk_ok: assert property (p_chk_ok) else $error("marked call refused");
   property p_chk_no;
      CHECK_IN.req && !CHECK_IN.classmark && !CHECK_IN.from_alarm_trunk
         |=> CHECK_INTERCEPT && !CHECK_CONNECT;
   endproperty
   a_chk_no: assert property (p_chk_no) else $error("stranger admitted");
   property p_ack_on; ALARM_SCAN[63] [*5] |-> ACK_IND; endproperty
   a_ack_on: assert property (p_ack_on) else $error("ack not shown");
   property p_ack_off; !ALARM_SCAN[63] [*5] |-> !ACK_IND; endproperty
   a_ack_off: assert property (p_ack_off) else $error("ack stuck");
   c_seize: cover property ($rose(TRUNK_SEIZE));
   c_retry: cover property ($fell(TRUNK_SEIZE) ##1 TRUNK_SEIZE);
   c_connect: cover property (CHECK_CONNECT);
   c_intercept: cover property (CHECK_INTERCEPT);
endmodule : asc_alarm_sender_checker
bind asc_alarm_sender asc_alarm_sender_checker #(.TRUNK_W(TRUNK_W)) u_checker (.*);
`default_nettype wire

/* File: bench/asc_trunk_model.sv */
// Far end: trunk and remote operator
`timescale 1ns/100ps
`default_nettype none
module asc_trunk_model (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    seize,
   input  wire logic                    answer_en,
   input  wire logic                    dial_en,
   output var  logic                    answer,
   output var  asc_pkg::asc_check_req_s check
);
   logic [7:0] cnt;
   // Cycles since seizure
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt <= 8'h00;
      else if (!seize) cnt <= 8'h00;
      else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
   end
   // Late answer, gone on release
   assign answer = seize && answer_en && cnt >= 8'h05;
   // One dial, inside the checking window
   always_comb begin
      check = '0;
      check.req = answer && dial_en && cnt == 8'h0C;
      check.from_alarm_trunk = check.req;
   end
endmodule : asc_trunk_model
`default_nettype wire

/* File: bench/asc_alarm_sender_test.sv */
// Bench for the alarm sending controller
`timescale 1ns/100ps
`default_nettype none
module asc_alarm_sender_test;
   logic        CLK, PREADY, PSLVERR, er, TRUNK_ANSWER, TRUNK_SEIZE, TRUNK_DEDICATED, TONE_ON;
   logic        ACK_IND, CHECK_CONNECT, CHECK_INTERCEPT;
   logic        RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic        answer_en = 1'b0, dial_en = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic [63:0] ALARM_SCAN = 64'h0;
   logic [1:0]  TRUNK_SELECT, sel;
   logic [3:0]  TONE_CODE, CHECK_TONE;
   int          num_errors = 0, tests_run = 0;
   // Far-end and local checking calls, merged
   asc_pkg::asc_check_req_s CHECK_IN, model_chk, tb_chk = '0;
   assign CHECK_IN = model_chk | tb_chk;
   // Ten-cycle tick keeps the timeouts short
   asc_alarm_sender #(.TICK_CYCLES(10)) dut (.*);
   asc_trunk_model far_end (
      .clk(CLK), .rst_n(RST_N), .seize(TRUNK_SEIZE), .answer_en(answer_en),
      .dial_en(dial_en), .answer(TRUNK_ANSWER), .check(model_chk));
   // Clock at 200 MHz
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   task results;
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task chk(input logic [31:0] exp, got, input string what);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer, held until ready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      wait_on(3, 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   function logic sig(input int k);
      case (k)
         0: return TRUNK_SEIZE;
         1: return CHECK_CONNECT;
         3: return PREADY;
         default: return TONE_ON;
      endcase
   endfunction : sig
   // Bounded wait for a level; running out ends the run as a failure
   task wait_on(input int k, input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (sig(k) !== lvl && n < 400);
      if (sig(k) !== lvl) begin
         num_errors++;
         results();
      end
   endtask : wait_on
   // One-cycle local call; answer read an edge later
   task call(input asc_pkg::asc_check_req_s r);
      tb_chk <= r;
      @(posedge CLK);
      tb_chk <= '0;
      @(posedge CLK);
   endtask : call
   task t_regs;
      apb(1'b0, asc_pkg::OFS_TONE, 32'h0);
      chk(32'h0009_8101, rd, "tone reg");
      apb(1'b0, asc_pkg::OFS_TIMER, 32'h0);
      chk(32'h0000_3C3C, rd, "timer reg");
      apb(1'b0, 8'h40, 32'h0);
      chk(32'h1, 32'(er), "unmapped err");
      chk(32'h0, rd, "unmapped data");
   endtask : t_regs
   // Off or excluded: no seizure
   task t_quiet(input logic [31:0] ctrl, input logic [63:0] scan);
      apb(1'b1, asc_pkg::OFS_CTRL, ctrl);
      ALARM_SCAN <= scan;
      repeat (40) @(posedge CLK);
      chk(32'h0, 32'(TRUNK_SEIZE), "quiet seize");
   endtask : t_quiet
   task t_send;
      apb(1'b1, asc_pkg::OFS_TIMER, 32'h0000_0302);
      apb(1'b1, asc_pkg::OFS_TONE, 32'h0009_8707);
      apb(1'b1, asc_pkg::OFS_CTRL, 32'h0000_0101);
      ALARM_SCAN <= 64'h0000_0000_0000_0100;
      wait_on(0, 1'b1);
      chk(32'h1, 32'(TONE_ON), "tone on");
      chk(32'h7, 32'(TONE_CODE), "tone code");
      chk(32'h1, 32'(TRUNK_DEDICATED), "dedicated");
      sel = TRUNK_SELECT + 2'h1;
      wait_on(0, 1'b0);
      wait_on(0, 1'b1);
      chk(32'(sel), 32'(TRUNK_SELECT), "retry trunk");
   endtask : t_send
   task t_check;
      answer_en <= 1'b1;
      dial_en <= 1'b1;
      wait_on(1, 1'b1);
      chk(32'h8, 32'(CHECK_TONE), "minor tone");
      dial_en <= 1'b0;
      repeat (3) @(posedge CLK);
      chk(32'h0, 32'(TRUNK_SEIZE), "released");
      ALARM_SCAN <= 64'h0000_0000_0000_0108;
      wait_on(0, 1'b1);
      call('{1'b1, 1'b0, 1'b0});
      chk(32'h1, 32'(CHECK_INTERCEPT), "intercept");
      ALARM_SCAN <= 64'h8000_0000_0000_0000;
      wait_on(2, 1'b0);
      call('{1'b1, 1'b0, 1'b1});
      chk(32'h1, 32'(CHECK_CONNECT), "marked call");
      chk(32'h9, 32'(CHECK_TONE), "no alarm tone");
      chk(32'h1, 32'(ACK_IND), "ack point");
   endtask : t_check
   initial begin
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      t_regs();
      t_quiet(32'h0, 64'h0000_0000_0000_0001);
      ALARM_SCAN <= 64'h0;
      t_send();
      t_check();
      t_quiet(32'h0000_0121, 64'h8000_0000_0000_0100);
      results();
   end
endmodule : asc_alarm_sender_test
`default_nettype wire
